/* pjg_params.svh */
// Purpose: Offsets, field positions and reset values of the port J block
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef PJG_PARAMS_SVH
`define PJG_PARAMS_SVH

// Register offsets on the plain register port
`define PJG_OFS_DATA   8'h28
`define PJG_OFS_LEVELS 8'h29
`define PJG_OFS_DIR    8'h2A
`define PJG_OFS_DRIVE  8'h2B
`define PJG_OFS_PULL   8'h2C
`define PJG_OFS_POL    8'h2D
`define PJG_OFS_IEN    8'h2E
`define PJG_OFS_IFLAG  8'h2F

// Pins that exist: bits 7, 6, 1 and 0
`define PJG_IMPL_MASK  8'hC3

// Reset values
`define PJG_RST_DATA   8'h00
`define PJG_RST_DIR    8'h00
`define PJG_RST_DRIVE  8'h00
`define PJG_RST_PULL   8'hC3
`define PJG_RST_POL    8'h00
`define PJG_RST_IEN    8'h00
`define PJG_RST_ZERO   8'h00
`define PJG_SYNC_RST   1'b1

// Shared pin positions
`define PJG_BIT_HI     7
`define PJG_BIT_LO     6

// Synchroniser depth in bus cycles
`define PJG_SYNC_CYCLES 2

`endif

/* pjg_pkg.sv */
// Purpose: Types shared by the port J block
// Assumes: Nothing
// Notes:   Constants live in pjg_params.svh
package pjg_pkg;
  typedef logic [7:0] pjg_byte_t;
  typedef logic [7:0] pjg_addr_t;
  // Owner of a shared pin, highest priority last
  typedef enum logic [1:0] {
    PJG_OWN_GPIO,
    PJG_OWN_I2C,
    PJG_OWN_CAN
  } pjg_owner_e;
endpackage

/* pjg_sync.sv */
// Purpose: Two flip-flop synchroniser for a vector of pin levels
// Assumes: Inputs asynchronous to clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ns
`default_nettype none
`include "pjg_params.svh"
module pjg_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;

  // Two stages, reset to the pulled-up level
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= {W{`PJG_SYNC_RST}};
      q      <= {W{`PJG_SYNC_RST}};
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule
`default_nettype wire

/* pjg_pin_flag.sv */
// Purpose: Edge detector and sticky flag for one pin
// Assumes: level already synchronised to clk
// Notes:   A set in the same cycle as a clear wins
`timescale 1ns/1ns
`default_nettype none
module pjg_pin_flag (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic level,
  input  wire logic rising_sel,
  input  wire logic clear,
  output logic      flag
);
  logic prev;
  logic active_edge;

  // Edge chosen by polarity: 1 rising, 0 falling
  assign active_edge = rising_sel ? (level & ~prev) : (~level & prev);

  // Previous level, reset high like the synchroniser
  always_ff @(posedge clk) begin
    if (srst) begin
      prev <= 1'b1;
    end else begin
      prev <= level;
    end
  end

  // Sticky flag, written one clears it
  always_ff @(posedge clk) begin
    if (srst) begin
      flag <= 1'b0;
    end else begin
      flag <= active_edge | (flag & ~clear);
    end
  end

  a_flag_edge_set: assert property (@(posedge clk) disable iff (srst)
    (rising_sel && level && !prev) |=> flag)
    else $error("Rising edge did not set flag");
  a_flag_w1c_clear: assert property (@(posedge clk) disable iff (srst)
    (clear && !active_edge) |=> !flag)
    else $error("Write one did not clear flag");
  a_flag_zero_hold: assert property (@(posedge clk) disable iff (srst)
    (flag && !clear) |=> flag)
    else $error("Flag lost without a clear");
  a_flag_once: assert property (@(posedge clk) disable iff (srst)
    (active_edge && clear) |=> (flag && !active_edge))
    else $error("Edge counted twice or lost");
endmodule
`default_nettype wire

/* pjg_port.sv */
// Purpose: Port J pin logic with CAN and I2C sharing and edge flags
// Assumes: One 10 MHz bus clock, synchronous active high reset
// Notes:   Pin pad controls are registered; pins sampled by two flops
`timescale 1ns/1ns
`default_nettype none
`include "pjg_params.svh"
module pjg_port (
  input  wire logic              CLK,
  input  wire logic              SRST,
  input  wire pjg_pkg::pjg_addr_t ADDR,
  input  wire pjg_pkg::pjg_byte_t WDATA,
  input  wire logic              WR_STROBE,
  input  wire logic              RD_STROBE,
  output pjg_pkg::pjg_byte_t     RDATA,
  input  wire pjg_pkg::pjg_byte_t PIN_IN,
  output pjg_pkg::pjg_byte_t     PIN_OUT,
  output pjg_pkg::pjg_byte_t     PIN_OE,
  output pjg_pkg::pjg_byte_t     PIN_REDUCED,
  output pjg_pkg::pjg_byte_t     PIN_PULL_UP,
  output pjg_pkg::pjg_byte_t     PIN_PULL_DOWN,
  input  wire logic              CAN_ENABLE,
  input  wire logic              CAN_TX,
  output logic                   CAN_RX,
  input  wire logic              I2C_ENABLE,
  input  wire logic              I2C_SCL_OUT,
  input  wire logic              I2C_SDA_OUT,
  output logic                   I2C_SCL_IN,
  output logic                   I2C_SDA_IN,
  output logic                   IRQ_REQ
);
  import pjg_pkg::*;

  localparam pjg_byte_t IMPL = `PJG_IMPL_MASK;

  pjg_byte_t  port_output_data;
  pjg_byte_t  port_direction;
  pjg_byte_t  port_drive_strength;
  pjg_byte_t  port_pull_enable;
  pjg_byte_t  port_polarity_select;
  pjg_byte_t  port_irq_enable;
  pjg_byte_t  port_irq_flags;
  pjg_byte_t  port_pin_levels;
  pjg_byte_t  flag_clear;
  pjg_byte_t  read_mux;
  pjg_byte_t  next_out;
  pjg_byte_t  next_oe;
  pjg_byte_t  next_reduced;
  pjg_byte_t  next_pull_up;
  pjg_byte_t  next_pull_down;
  pjg_owner_e shared_owner;
  logic       wr_data;
  logic       wr_dir;
  logic       wr_drive;
  logic       wr_pull;
  logic       wr_pol;
  logic       wr_ien;
  logic       wr_iflag;

  // Write decode; the pin level register has no write path
  assign wr_data  = WR_STROBE && (ADDR == `PJG_OFS_DATA);
  assign wr_dir   = WR_STROBE && (ADDR == `PJG_OFS_DIR);
  assign wr_drive = WR_STROBE && (ADDR == `PJG_OFS_DRIVE);
  assign wr_pull  = WR_STROBE && (ADDR == `PJG_OFS_PULL);
  assign wr_pol   = WR_STROBE && (ADDR == `PJG_OFS_POL);
  assign wr_ien   = WR_STROBE && (ADDR == `PJG_OFS_IEN);
  assign wr_iflag = WR_STROBE && (ADDR == `PJG_OFS_IFLAG);

  // Pin levels pass two flops before any use
  pjg_sync #(
    .W (8)
  ) u_sync (
    .clk  (CLK),
    .srst (SRST),
    .d    (PIN_IN),
    .q    (port_pin_levels)
  );

  // Output data register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      port_output_data <= `PJG_RST_DATA;
    end else if (wr_data) begin
      port_output_data <= WDATA & IMPL;
    end
  end

  // Direction register, written only by software
  always_ff @(posedge CLK) begin
    if (SRST) begin
      port_direction <= `PJG_RST_DIR;
    end else if (wr_dir) begin
      port_direction <= WDATA & IMPL;
    end
  end

  // Reduced drive register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      port_drive_strength <= `PJG_RST_DRIVE;
    end else if (wr_drive) begin
      port_drive_strength <= WDATA & IMPL;
    end
  end

  // Pull enable register, pull-ups on out of reset
  always_ff @(posedge CLK) begin
    if (SRST) begin
      port_pull_enable <= `PJG_RST_PULL;
    end else if (wr_pull) begin
      port_pull_enable <= WDATA & IMPL;
    end
  end

  // Polarity register: 0 falling and pull-up, 1 rising and pull-down
  always_ff @(posedge CLK) begin
    if (SRST) begin
      port_polarity_select <= `PJG_RST_POL;
    end else if (wr_pol) begin
      port_polarity_select <= WDATA & IMPL;
    end
  end

  // Interrupt enable register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      port_irq_enable <= `PJG_RST_IEN;
    end else if (wr_ien) begin
      port_irq_enable <= WDATA & IMPL;
    end
  end

  // Clear strobes, one per flag bit written as one
  assign flag_clear = wr_iflag ? WDATA : `PJG_RST_ZERO;

  // One flag cell per existing pin; absent pins read zero
  for (genvar i = 0; i < 8; i++) begin : g_flag
    if (IMPL[i]) begin : g_pin
      pjg_pin_flag u_flag (
        .clk        (CLK),
        .srst       (SRST),
        .level      (port_pin_levels[i]),
        .rising_sel (port_polarity_select[i]),
        .clear      (flag_clear[i]),
        .flag       (port_irq_flags[i])
      );
    end else begin : g_none
      assign port_irq_flags[i] = 1'b0;
    end
  end

  // Owner of the two shared pins by fixed priority
  always_comb begin
    if (CAN_ENABLE) begin
      shared_owner = PJG_OWN_CAN;
    end else if (I2C_ENABLE) begin
      shared_owner = PJG_OWN_I2C;
    end else begin
      shared_owner = PJG_OWN_GPIO;
    end
  end

  // Pad controls per pin from its owner
  always_comb begin
    next_out       = '0;
    next_oe        = '0;
    next_pull_up   = '0;
    next_pull_down = '0;
    for (int i = 0; i < 8; i++) begin
      if (IMPL[i] && (i >= `PJG_BIT_LO)) begin
        case (shared_owner)
          PJG_OWN_CAN: begin
            if (i == `PJG_BIT_HI) begin
              next_out[i] = CAN_TX;
              next_oe[i]  = 1'b1;
            end else begin
              next_pull_up[i] = port_pull_enable[i] &
                                ~port_polarity_select[i];
              next_pull_down[i] = port_pull_enable[i] &
                                  port_polarity_select[i];
            end
          end
          PJG_OWN_I2C: begin
            // Drive low only; high comes from the pull
            next_oe[i] = (i == `PJG_BIT_HI) ? ~I2C_SCL_OUT
                                            : ~I2C_SDA_OUT;
            next_pull_up[i] = port_pull_enable[i] &
                              ~port_polarity_select[i];
          end
          default: begin
            next_out[i] = port_output_data[i];
            next_oe[i]  = port_direction[i];
            next_pull_up[i] = port_pull_enable[i] & ~port_direction[i] &
                              ~port_polarity_select[i];
            next_pull_down[i] = port_pull_enable[i] & ~port_direction[i] &
                                port_polarity_select[i];
          end
        endcase
      end else if (IMPL[i]) begin
        next_out[i] = port_output_data[i];
        next_oe[i]  = port_direction[i];
        next_pull_up[i] = port_pull_enable[i] & ~port_direction[i] &
                          ~port_polarity_select[i];
        next_pull_down[i] = port_pull_enable[i] & ~port_direction[i] &
                            port_polarity_select[i];
      end
    end
  end

  // Reduced drive only where the pin is driven
  assign next_reduced = port_drive_strength & next_oe;

  // Registered pad controls; reset leaves inputs with pull-ups
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PIN_OUT       <= `PJG_RST_ZERO;
      PIN_OE        <= `PJG_RST_ZERO;
      PIN_REDUCED   <= `PJG_RST_ZERO;
      PIN_PULL_UP   <= `PJG_RST_PULL;
      PIN_PULL_DOWN <= `PJG_RST_ZERO;
    end else begin
      PIN_OUT       <= next_out;
      PIN_OE        <= next_oe;
      PIN_REDUCED   <= next_reduced;
      PIN_PULL_UP   <= next_pull_up;
      PIN_PULL_DOWN <= next_pull_down;
    end
  end

  // Pin levels handed to the peripherals
  always_ff @(posedge CLK) begin
    if (SRST) begin
      CAN_RX     <= `PJG_SYNC_RST;
      I2C_SCL_IN <= `PJG_SYNC_RST;
      I2C_SDA_IN <= `PJG_SYNC_RST;
    end else begin
      CAN_RX     <= port_pin_levels[`PJG_BIT_LO];
      I2C_SCL_IN <= port_pin_levels[`PJG_BIT_HI];
      I2C_SDA_IN <= port_pin_levels[`PJG_BIT_LO];
    end
  end

  // Request while any enabled flag is set
  always_ff @(posedge CLK) begin
    if (SRST) begin
      IRQ_REQ <= 1'b0;
    end else begin
      IRQ_REQ <= |(port_irq_flags & port_irq_enable);
    end
  end

  // Read select; unmapped offsets read zero
  always_comb begin
    case (ADDR)
      `PJG_OFS_DATA:   read_mux = (port_direction & port_output_data) |
                                  (~port_direction & port_pin_levels &
                                   IMPL);
      `PJG_OFS_LEVELS: read_mux = port_pin_levels & IMPL;
      `PJG_OFS_DIR:    read_mux = port_direction;
      `PJG_OFS_DRIVE:  read_mux = port_drive_strength;
      `PJG_OFS_PULL:   read_mux = port_pull_enable;
      `PJG_OFS_POL:    read_mux = port_polarity_select;
      `PJG_OFS_IEN:    read_mux = port_irq_enable;
      `PJG_OFS_IFLAG:  read_mux = port_irq_flags;
      default:         read_mux = `PJG_RST_ZERO;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= `PJG_RST_ZERO;
    end else if (RD_STROBE) begin
      RDATA <= read_mux;
    end else begin
      RDATA <= `PJG_RST_ZERO;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);

  // Checks on ownership, pads, readback and requests
  a_reset_pull_up: assert property (
    @(posedge CLK) disable iff (1'b0)
    SRST |=> (PIN_OE == 8'h00 && PIN_PULL_UP == IMPL))
    else $error("Reset did not leave pulled-up inputs");
  a_can_tx_owns: assert property (
    CAN_ENABLE |=> (PIN_OE[7] && PIN_OUT[7] == $past(CAN_TX)))
    else $error("CAN transmit pin not driven by CAN");
  a_can_rx_input: assert property (
    CAN_ENABLE |=> !PIN_OE[6])
    else $error("CAN receive pin not an input");
  a_i2c_open_drain: assert property (
    (!CAN_ENABLE && I2C_ENABLE) |=>
    (PIN_OUT[7:6] == 2'b00 && PIN_OE[7] == !$past(I2C_SCL_OUT) &&
     PIN_OE[6] == !$past(I2C_SDA_OUT)))
    else $error("I2C pin driven high or wrong enable");
  a_owner_priority: assert property (
    (CAN_ENABLE && I2C_ENABLE && !CAN_TX) |=> (PIN_OE[7] && !PIN_OUT[7]))
    else $error("I2C took pin from enabled CAN");
  a_gpio_direction: assert property (
    1'b1 |=> PIN_OE[1:0] == $past(port_direction[1:0]))
    else $error("Low pins do not follow direction");
  a_owner_released: assert property (
    (!CAN_ENABLE && !I2C_ENABLE) |=>
    PIN_OE[7:6] == $past(port_direction[7:6]))
    else $error("Released pins ignore direction");
  a_dir_kept: assert property (
    CAN_ENABLE |=> port_direction == ($past(wr_dir) ?
                   ($past(WDATA) & IMPL) : $past(port_direction)))
    else $error("Override changed direction register");
  a_drive_output: assert property (
    (PIN_REDUCED & ~PIN_OE) == 8'h00)
    else $error("Reduced drive on an input pin");
  a_pull_pushpull: assert property (
    (port_direction[1] && !wr_dir) |=> (!PIN_PULL_UP[1] && !PIN_PULL_DOWN[1]))
    else $error("Pull active on push-pull output");
  a_unimpl_zero: assert property (
    ((port_direction | port_pull_enable | port_irq_flags) & ~IMPL) == 8'h00)
    else $error("Absent bit became set");
  a_data_read: assert property (
    (RD_STROBE && ADDR == `PJG_OFS_DATA && port_direction == IMPL) |=>
    RDATA == $past(port_output_data))
    else $error("Data read ignored stored outputs");
  a_levels_read: assert property (
    (RD_STROBE && ADDR == `PJG_OFS_LEVELS &&
     (PIN_IN & IMPL) == ($past(PIN_IN) & IMPL) &&
     (PIN_IN & IMPL) == ($past(PIN_IN, 2) & IMPL)) |=>
    RDATA == ($past(PIN_IN) & IMPL))
    else $error("Pin level read wrong");
  a_irq_masked: assert property (
    ((port_irq_flags & port_irq_enable) == 8'h00) |=> !IRQ_REQ)
    else $error("Request raised with no enabled flag");
  a_irq_raised: assert property (
    ((port_irq_flags & port_irq_enable) != 8'h00) |=> IRQ_REQ)
    else $error("Enabled flag raised no request");
endmodule
`default_nettype wire

/* pjg_far_side.sv */
// Purpose: Pin side of port J: pads, pulls and outside drivers
// Assumes: The bench never drives a pin against the block
// Notes:   An undriven, unpulled pin toggles every cycle
`timescale 1ns/1ns
`default_nettype none
module pjg_far_side (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pull_up,
  input  wire logic [7:0] pull_down,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] level
);
  logic [7:0] drift = 8'h00;
  // Floating pins wander so a stale level is never read back
  always @(posedge clk) begin
    drift <= ~drift;
  end
  // Block drive first, then outside drive, then the pull devices
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = (pin_oe[i] === 1'b1) ? pin_out[i] :
                 (ext_en[i] === 1'b1) ? ext_val[i] :
                 (pull_up[i] === 1'b1) ? 1'b1 :
                 (pull_down[i] === 1'b1) ? 1'b0 : drift[i];
    end
  end
endmodule
`default_nettype wire

/* test_pjg_port.sv */
// Purpose: Self-checking bench for the port J block
// Assumes: Pins modelled by pjg_far_side; CAN and I2C driven here
// Notes:   Reads queue their expectation; a monitor compares
`timescale 1ns/1ns
`default_nettype none
module test_pjg_port;
  import pjg_pkg::*;
  localparam pjg_byte_t IM = 8'hC3;
  logic        CLK = 1'b0;
  logic        SRST = 1'b1;
  logic        WR_STROBE = 1'b0;
  logic        RD_STROBE = 1'b0;
  logic [4:0]  ctl_v = 5'b01011;
  pjg_addr_t   ADDR = 8'h00;
  pjg_byte_t   WDATA = 8'h00;
  pjg_byte_t   ext_en = 8'h00;
  pjg_byte_t   ext_val = 8'h00;
  pjg_byte_t   RDATA, PIN_IN, PIN_OUT, PIN_OE, PIN_REDUCED;
  pjg_byte_t   PIN_PULL_UP, PIN_PULL_DOWN, rnd, m;
  logic        CAN_RX, I2C_SCL_IN, I2C_SDA_IN, IRQ_REQ;
  logic        rd_seen = 1'b0;
  pjg_byte_t   exp_q[$];
  string       name_q[$];
  int          fails = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          pins[4] = '{0, 1, 6, 7};
  pjg_addr_t   rw_ofs[4] = '{8'h2B, 8'h2C, 8'h2D, 8'h2E};
  logic [15:0] rst_tab[9] = '{16'h28C3, 16'h29C3, 16'h2A00, 16'h2B00,
                              16'h2CC3, 16'h2D00, 16'h2E00, 16'h2F00,
                              16'h3000};
  // Bus clock, 100 ns period
  always #50 CLK = ~CLK;
  // Block under test and its pins
  pjg_port dut (
    .CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE), .RDATA(RDATA),
    .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PIN_REDUCED(PIN_REDUCED), .PIN_PULL_UP(PIN_PULL_UP),
    .PIN_PULL_DOWN(PIN_PULL_DOWN), .CAN_ENABLE(ctl_v[4]),
    .CAN_TX(ctl_v[3]), .CAN_RX(CAN_RX), .I2C_ENABLE(ctl_v[2]),
    .I2C_SCL_OUT(ctl_v[1]), .I2C_SDA_OUT(ctl_v[0]),
    .I2C_SCL_IN(I2C_SCL_IN), .I2C_SDA_IN(I2C_SDA_IN), .IRQ_REQ(IRQ_REQ)
  );
  pjg_far_side far (
    .clk(CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pull_up(PIN_PULL_UP),
    .pull_down(PIN_PULL_DOWN), .ext_en(ext_en), .ext_val(ext_val),
    .level(PIN_IN)
  );
  // Compare one value and count it
  task automatic check(input string what, input pjg_byte_t seen,
                       input pjg_byte_t exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle register write; strobe stays up for a following access
  task automatic wr(input pjg_addr_t a, input pjg_byte_t d);
    @(posedge CLK);
    ADDR      <= a;
    WDATA     <= d;
    WR_STROBE <= 1'b1;
    RD_STROBE <= 1'b0;
  endtask
  // One-cycle register read; the expectation goes on the queue
  task automatic rd(input pjg_addr_t a, input pjg_byte_t exp,
                    input string what);
    @(posedge CLK);
    ADDR      <= a;
    WR_STROBE <= 1'b0;
    RD_STROBE <= 1'b1;
    exp_q.push_back(exp);
    name_q.push_back(what);
  endtask
  // Quiet bus for n cycles, then let outputs settle
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge CLK);
      WR_STROBE <= 1'b0;
      RD_STROBE <= 1'b0;
    end
    #10;
  endtask
  // Controller lines and outside pin drive
  task automatic ctl(input logic [4:0] c, input pjg_byte_t en,
                     input pjg_byte_t v);
    @(posedge CLK);
    ctl_v     <= c;
    ext_en    <= en;
    ext_val   <= v;
    WR_STROBE <= 1'b0;
    RD_STROBE <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Take the oldest note whenever read data stands
  always @(negedge CLK) begin
    if (rd_seen) begin
      check(name_q.pop_front(), RDATA, exp_q.pop_front());
    end
  end
  // Mark read-data cycles and cut a hang short
  always @(posedge CLK) begin
    rd_seen <= RD_STROBE;
    cycles = cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      results();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(32'hC079083F));
    repeat (12) @(posedge CLK);
    SRST <= 1'b0;
    idle(2);
    check("oe", PIN_OE, 8'h00);
    check("pull up", PIN_PULL_UP, IM);
    check("pull down", PIN_PULL_DOWN, 8'h00);
    check("reduced", PIN_REDUCED, 8'h00);
    check("irq", {7'h00, IRQ_REQ}, 8'h00);
    foreach (rst_tab[i]) begin
      rd(rst_tab[i][15:8], rst_tab[i][7:0], "reset");
    end
    foreach (rw_ofs[i]) begin
      rnd = pjg_byte_t'($urandom);
      wr(rw_ofs[i], rnd);
      rd(rw_ofs[i], rnd & IM, "rw");
    end
    wr(8'h2B, 8'h00);
    wr(8'h2C, IM);
    wr(8'h2D, 8'h00);
    wr(8'h2E, 8'h00);
    wr(8'h29, 8'h00);
    idle(5);
    wr(8'hFF, 8'hFF);
    wr(8'h2F, 8'hFF);
    rd(8'h2F, 8'h00, "flags cleared");
    rd(8'h29, IM, "levels");
    // General-purpose output, then input with outside drive
    rnd = pjg_byte_t'($urandom);
    wr(8'h28, rnd);
    wr(8'h2A, 8'hFF);
    wr(8'h2B, IM);
    idle(4);
    check("oe", PIN_OE, IM);
    check("out", PIN_OUT & IM, rnd & IM);
    check("reduced", PIN_REDUCED, IM);
    check("pull up", PIN_PULL_UP, 8'h00);
    rd(8'h28, rnd & IM, "data out");
    rd(8'h29, rnd & IM, "levels out");
    wr(8'h2A, 8'h00);
    ctl(5'b01011, IM, ~rnd);
    idle(4);
    check("reduced", PIN_REDUCED, 8'h00);
    check("pull up", PIN_PULL_UP, IM);
    rd(8'h28, ~rnd & IM, "data in");
    rd(8'h29, ~rnd & IM, "levels in");
    wr(8'h2D, IM);
    idle(2);
    check("pull down", PIN_PULL_DOWN, IM);
    check("pull up", PIN_PULL_UP, 8'h00);
    wr(8'h2D, 8'h00);
    // Edge flags, masking and clearing on every pin
    foreach (pins[i]) begin
      m = 8'h01 << pins[i];
      ctl(5'b01011, IM, IM);
      idle(4);
      wr(8'h2F, 8'hFF);
      ctl(5'b01011, IM, IM & ~m);
      idle(1);
      // Clear lands in the cycle the edge sets the flag; the set wins
      wr(8'h2F, m);
      idle(3);
      rd(8'h2F, m, "fall flag");
      idle(1);
      check("irq masked", {7'h00, IRQ_REQ}, 8'h00);
      wr(8'h2E, m);
      idle(3);
      check("irq", {7'h00, IRQ_REQ}, 8'h01);
      wr(8'h2F, ~m);
      rd(8'h2F, m, "zero write");
      wr(8'h2F, m);
      idle(3);
      rd(8'h2F, 8'h00, "one write");
      idle(1);
      check("irq cleared", {7'h00, IRQ_REQ}, 8'h00);
      ctl(5'b01011, IM, IM);
      idle(5);
      rd(8'h2F, 8'h00, "rise ignored");
      wr(8'h2D, m);
      ctl(5'b01011, IM, IM & ~m);
      idle(5);
      wr(8'h2F, 8'hFF);
      ctl(5'b01011, IM, IM);
      idle(5);
      rd(8'h2F, m, "rise flag");
      wr(8'h2F, 8'hFF);
      wr(8'h2D, 8'h00);
      wr(8'h2E, 8'h00);
    end
    // CAN over I2C over general purpose
    wr(8'h2A, 8'h00);
    ctl(5'b10111, 8'h00, 8'h00);
    idle(4);
    check("can oe", PIN_OE & 8'hC0, 8'h80);
    check("can tx", PIN_OUT & 8'h80, 8'h00);
    ctl(5'b11111, 8'h40, 8'h00);
    idle(5);
    check("can tx", PIN_OUT & 8'h80, 8'h80);
    check("can rx", {7'h00, CAN_RX}, 8'h00);
    wr(8'h2A, IM);
    idle(2);
    check("can oe", PIN_OE & 8'hC0, 8'h80);
    rd(8'h2A, IM, "dir kept");
    ctl(5'b00100, 8'h00, 8'h00);
    idle(4);
    check("i2c oe", PIN_OE & 8'hC0, 8'hC0);
    check("i2c out", PIN_OUT & 8'hC0, 8'h00);
    check("i2c in", {6'h00, I2C_SCL_IN, I2C_SDA_IN}, 8'h00);
    ctl(5'b00111, 8'h80, 8'h00);
    idle(5);
    check("i2c oe", PIN_OE & 8'hC0, 8'h00);
    check("i2c pull", PIN_PULL_UP & 8'hC0, 8'hC0);
    check("i2c pull", PIN_PULL_DOWN & 8'hC0, 8'h00);
    check("i2c in", {6'h00, I2C_SCL_IN, I2C_SDA_IN}, 8'h01);
    ctl(5'b01011, 8'h00, 8'h00);
    idle(3);
    check("gpio oe", PIN_OE & 8'hC0, 8'hC0);
    rd(8'h2A, IM, "dir kept");
    idle(3);
    // Mid-run reset returns every pin to a pulled-up input
    @(posedge CLK);
    SRST <= 1'b1;
    idle(3);
    check("rst oe", PIN_OE, 8'h00);
    check("rst pull", PIN_PULL_UP, IM);
    @(posedge CLK);
    SRST <= 1'b0;
    rd(8'h2A, 8'h00, "rst dir");
    idle(3);
    results();
  end
endmodule
`default_nettype wire
